// File: logic/scs_pkg.sv
// Purpose: Constants for the scanner channel sequencer.
// Assumes: 40 MHz system clock, register port with read data one cycle late.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package scs_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE      = 8'h00;  // Scan mode and output function
  localparam logic [7:0] ADDR_MANUAL    = 8'h04;  // Manual channel code
  localparam logic [7:0] ADDR_DWELL     = 8'h08;  // Dwell seconds
  localparam logic [7:0] ADDR_ENABLE    = 8'h0c;  // Per-channel enable mask
  localparam logic [7:0] ADDR_SETUP     = 8'h10;  // Setup pointer channel code
  localparam logic [7:0] ADDR_CURVE     = 8'h14;  // Curve of pointed channel
  localparam logic [7:0] ADDR_STATUS    = 8'h18;  // Active channel, mode
  localparam logic [7:0] ADDR_GLOBAL    = 8'h1c;  // Global input setting word
  localparam logic [7:0] ADDR_SAMPLE    = 8'h20;  // Reading capture of active channel
  localparam logic [7:0] ADDR_HELD      = 8'h24;  // Held reading of pointed channel
  // ------------------------------------------------------------
  // Field layouts and reset values
  // ------------------------------------------------------------
  localparam int          MODE_LSB       = 0;     // Mode field bits 1:0
  localparam int          DOFUNC_BIT     = 2;     // Digital outputs in scanner function
  localparam logic [3:0]  RST_CODE       = 4'h0;  // First channel
  localparam logic [15:0] RST_ENABLE     = 16'hffff;
  localparam logic [7:0]  DWELL_MIN_S    = 8'h02;
  localparam logic [7:0]  DWELL_MAX_S    = 8'hc8;
  localparam logic [7:0]  RST_DWELL_S    = 8'h02;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_HZ         = 40000000;
  localparam int          SECOND_S       = 1;
  localparam int          SECOND_CYCLES  = CLK_HZ * SECOND_S;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SCS_OFF    = 2'b00,
    SCS_MANUAL = 2'b01,
    SCS_AUTO   = 2'b10,
    SCS_SLAVE  = 2'b11
  } scs_mode_t;
endpackage
`default_nettype wire

// File: logic/scs_sequencer.sv
// Purpose: Active channel selection for an external sixteen-way sensor scanner.
// Assumes: Single 40 MHz clock; code inputs are asynchronous pins.
// Notes:   Readings arrive as a word with a valid strobe for the active channel.
`default_nettype none
module scs_sequencer #(
  parameter int CURVE_W       = 8,                        // Curve selector width
  parameter int DATA_W        = 24,                       // Reading width
  parameter int SECOND_CYCLES = scs_pkg::SECOND_CYCLES    // Cycles per second
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              chan_code_in_bit3,
  input  wire logic              chan_code_in_bit2,
  input  wire logic              chan_code_in_bit1,
  input  wire logic              chan_code_in_bit0,
  output logic                   chan_code_out_bit3,
  output logic                   chan_code_out_bit2,
  output logic                   chan_code_out_bit1,
  output logic                   chan_code_out_bit0,
  output logic                   chan_code_out_en,
  output logic      [3:0]        active_chan,
  output logic      [CURVE_W-1:0] active_curve,
  output logic                   scan_active,
  input  wire logic [DATA_W-1:0] reading,
  input  wire logic              reading_valid
);
  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  scs_pkg::scs_mode_t mode_reg;                 // Scan mode
  logic               dofunc_reg;               // Outputs in scanner function
  logic [3:0]         manual_reg;               // Chosen manual channel code
  logic [7:0]         dwell_reg;                // Dwell in seconds
  logic [15:0]        enable_reg;               // Per-channel enable flags
  logic [3:0]         setup_reg;                // Setup pointer
  logic [CURVE_W-1:0] curve_reg [16];           // Per-channel curve
  logic [31:0]        global_reg;               // Setting shared by all channels
  logic [DATA_W-1:0]  held_reg  [16];           // Last valid reading per channel
  logic [3:0]         active_reg;               // Active channel code
  logic [3:0]         active_next;
  logic [31:0]        tick_reg;                 // Cycle count within a second
  logic [7:0]         sec_reg;                  // Seconds spent on channel
  logic [31:0]        reg_rdata_next;
  logic [3:0]         in_meta_reg, in_s2_reg, in_s3_reg, in_code_reg;

  // Dwell clamped into its legal span so a bad write cannot stall or race
  function automatic logic [7:0] clamp_dwell(input logic [7:0] v);
    if (v < scs_pkg::DWELL_MIN_S) begin
      return scs_pkg::DWELL_MIN_S;
    end else if (v > scs_pkg::DWELL_MAX_S) begin
      return scs_pkg::DWELL_MAX_S;
    end
    return v;
  endfunction

  // Next enabled channel above cur, wrapping; holds cur if none other
  function automatic logic [3:0] next_enabled(input logic [3:0] cur, input logic [15:0] en);
    logic [3:0] idx;
    logic       found;
    next_enabled = cur;
    found = 1'b0;
    for (int i = 1; i < 16; i++) begin
      idx = cur + 4'(i);
      if (!found && en[idx]) begin
        next_enabled = idx;
        found = 1'b1;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire wr_mode   = reg_wr && reg_addr == scs_pkg::ADDR_MODE;
  wire wr_manual = reg_wr && reg_addr == scs_pkg::ADDR_MANUAL;
  wire wr_dwell  = reg_wr && reg_addr == scs_pkg::ADDR_DWELL;
  wire wr_enable = reg_wr && reg_addr == scs_pkg::ADDR_ENABLE;
  wire wr_setup  = reg_wr && reg_addr == scs_pkg::ADDR_SETUP;
  wire wr_curve  = reg_wr && reg_addr == scs_pkg::ADDR_CURVE;
  wire wr_global = reg_wr && reg_addr == scs_pkg::ADDR_GLOBAL;
  wire is_auto   = mode_reg == scs_pkg::SCS_AUTO;
  wire sec_tick  = tick_reg == 32'(SECOND_CYCLES - 1);
  wire dwell_done = is_auto && sec_tick && (sec_reg + 8'h01 >= dwell_reg);
  wire drive_out = dofunc_reg && (mode_reg == scs_pkg::SCS_MANUAL || is_auto);
  wire in_stable = in_s2_reg == in_s3_reg;

  // ------------------------------------------------------------
  // Pin synchroniser: three stages, accept when last two agree
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_meta_reg <= 4'h0;
      in_s2_reg   <= 4'h0;
      in_s3_reg   <= 4'h0;
      in_code_reg <= 4'h0;
    end else begin
      in_meta_reg <= {chan_code_in_bit3, chan_code_in_bit2, chan_code_in_bit1, chan_code_in_bit0};
      in_s2_reg   <= in_meta_reg;
      in_s3_reg   <= in_s2_reg;
      if (in_stable) begin
        in_code_reg <= in_s3_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Active channel selection
  // ------------------------------------------------------------
  always_comb begin
    case (mode_reg)
      scs_pkg::SCS_MANUAL: active_next = manual_reg;
      scs_pkg::SCS_AUTO:   active_next = dwell_done ?
                                         next_enabled(active_reg, enable_reg) : active_reg;
      scs_pkg::SCS_SLAVE:  active_next = in_code_reg;
      default:             active_next = active_reg;                     // off holds
    endcase
  end

  // Dwell timer: restarts whenever not in auto or dwell ended
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_reg <= 32'h0;
      sec_reg  <= 8'h00;
    end else if (!is_auto || dwell_done) begin
      tick_reg <= 32'h0;
      sec_reg  <= 8'h00;
    end else if (sec_tick) begin
      tick_reg <= 32'h0;
      sec_reg  <= sec_reg + 8'h01;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg   <= scs_pkg::SCS_OFF;
      dofunc_reg <= 1'b0;
      manual_reg <= scs_pkg::RST_CODE;
      dwell_reg  <= scs_pkg::RST_DWELL_S;
      enable_reg <= scs_pkg::RST_ENABLE;
      setup_reg  <= scs_pkg::RST_CODE;
      global_reg <= 32'h0;
      active_reg <= scs_pkg::RST_CODE;
    end else begin
      if (wr_mode) begin
        mode_reg   <= scs_pkg::scs_mode_t'(reg_wdata[scs_pkg::MODE_LSB +: 2]);
        dofunc_reg <= reg_wdata[scs_pkg::DOFUNC_BIT];
      end
      if (wr_manual) manual_reg <= reg_wdata[3:0];
      if (wr_dwell)  dwell_reg  <= clamp_dwell(reg_wdata[7:0]);
      if (wr_enable) enable_reg <= reg_wdata[15:0];
      if (wr_setup)  setup_reg  <= reg_wdata[3:0];
      if (wr_global) global_reg <= reg_wdata;
      active_reg <= active_next;
    end
  end

  // Per-channel curve and held reading storage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        curve_reg[i] <= '0;
        held_reg[i]  <= '0;
      end
    end else begin
      if (wr_curve) curve_reg[setup_reg] <= reg_wdata[CURVE_W-1:0];
      if (reading_valid && mode_reg != scs_pkg::SCS_OFF) begin
        held_reg[active_reg] <= reading;
      end
    end
  end

  // ------------------------------------------------------------
  // Read port and outputs
  // ------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      scs_pkg::ADDR_MODE:   reg_rdata_next = {29'h0, dofunc_reg, mode_reg};
      scs_pkg::ADDR_MANUAL: reg_rdata_next = {28'h0, manual_reg};
      scs_pkg::ADDR_DWELL:  reg_rdata_next = {24'h0, dwell_reg};
      scs_pkg::ADDR_ENABLE: reg_rdata_next = {16'h0, enable_reg};
      scs_pkg::ADDR_SETUP:  reg_rdata_next = {28'h0, setup_reg};
      scs_pkg::ADDR_CURVE:  reg_rdata_next = 32'(curve_reg[setup_reg]);
      scs_pkg::ADDR_STATUS: reg_rdata_next = {16'h0, sec_reg, 2'h0, mode_reg, active_reg};
      scs_pkg::ADDR_GLOBAL: reg_rdata_next = global_reg;
      scs_pkg::ADDR_SAMPLE: reg_rdata_next = 32'(held_reg[active_reg]);
      scs_pkg::ADDR_HELD:   reg_rdata_next = 32'(held_reg[setup_reg]);
      default:              reg_rdata_next = 32'h0;  // Unmapped reads zero
    endcase
  end

  // Read data and pins registered; code pins low when not reporting
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
      {chan_code_out_bit3, chan_code_out_bit2, chan_code_out_bit1, chan_code_out_bit0} <= 4'h0;
      chan_code_out_en <= 1'b1;
    end else begin
      reg_rdata <= reg_rd ? reg_rdata_next : 32'h0;
      {chan_code_out_bit3, chan_code_out_bit2, chan_code_out_bit1, chan_code_out_bit0} <=
        drive_out ? active_next : 4'h0;
      chan_code_out_en <= !drive_out;
    end
  end

  assign active_chan  = active_reg;
  assign active_curve = curve_reg[active_reg];
  assign scan_active  = mode_reg != scs_pkg::SCS_OFF;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  wire [3:0] out_code = {chan_code_out_bit3, chan_code_out_bit2, chan_code_out_bit1, chan_code_out_bit0};
  property p_out_follows;
    @(posedge sys_clk) disable iff (rst) ##1 !chan_code_out_en |-> out_code == active_reg;
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("code pins differ from active channel");
  property p_out_off;
    @(posedge sys_clk) disable iff (rst) (mode_reg == scs_pkg::SCS_SLAVE || mode_reg == scs_pkg::SCS_OFF
      || !dofunc_reg) |=> chan_code_out_en;
  endproperty
  a_out_off: assert property (p_out_off) else $error("code pins driven outside reporting modes");
  property p_manual;
    @(posedge sys_clk) disable iff (rst) mode_reg == scs_pkg::SCS_MANUAL |=> active_reg == $past(manual_reg);
  endproperty
  a_manual: assert property (p_manual) else $error("manual channel not applied");
  property p_slave;
    @(posedge sys_clk) disable iff (rst) mode_reg == scs_pkg::SCS_SLAVE |=> active_reg == $past(in_code_reg);
  endproperty
  a_slave: assert property (p_slave) else $error("slave code not followed");
  property p_off_hold;
    @(posedge sys_clk) disable iff (rst) mode_reg == scs_pkg::SCS_OFF |=> $stable(active_reg);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("channel moved while off");
  property p_auto_enabled;
    @(posedge sys_clk) disable iff (rst) is_auto && dwell_done |=>
      enable_reg[active_reg] || active_reg == $past(active_reg);
  endproperty
  a_auto_enabled: assert property (p_auto_enabled) else $error("auto moved to disabled channel");
  property p_auto_dwell;
    @(posedge sys_clk) disable iff (rst) is_auto && !dwell_done && $past(is_auto) |=> $stable(active_reg);
  endproperty
  a_auto_dwell: assert property (p_auto_dwell) else $error("auto moved before dwell");
  property p_dwell_range;
    @(posedge sys_clk) disable iff (rst) dwell_reg >= scs_pkg::DWELL_MIN_S && dwell_reg <= scs_pkg::DWELL_MAX_S;
  endproperty
  a_dwell_range: assert property (p_dwell_range) else $error("dwell outside range");
  property p_held;
    @(posedge sys_clk) disable iff (rst) reading_valid && scan_active |=>
      held_reg[$past(active_reg)] == $past(reading);
  endproperty
  a_held: assert property (p_held) else $error("reading not held");
  c_auto_step: cover property (@(posedge sys_clk) disable iff (rst) dwell_done ##1 $changed(active_reg));
  c_slave: cover property (@(posedge sys_clk) disable iff (rst)
    mode_reg == scs_pkg::SCS_SLAVE ##1 $changed(active_reg));
  c_manual_out: cover property (@(posedge sys_clk) disable iff (rst)
    mode_reg == scs_pkg::SCS_MANUAL && !chan_code_out_en);
endmodule
`default_nettype wire

// File: testbench/scs_scanner_model.sv
// Purpose: External scanner that sits on the channel code pins.
// Assumes: Code lines are plain push-pull levels with no pulls.
// Notes:   The bench chooses the code that the scanner presents.
`default_nettype none
module scs_scanner_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] sel_code,
  input  wire logic       code_out_bit3,
  input  wire logic       code_out_bit2,
  input  wire logic       code_out_bit1,
  input  wire logic       code_out_bit0,
  input  wire logic       code_out_en_n,
  output logic            chan_code_in_bit3,
  output logic            chan_code_in_bit2,
  output logic            chan_code_in_bit1,
  output logic            chan_code_in_bit0,
  output logic      [3:0] seen_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Selection lines, channel minus one, bit3 first
  // ----------------------------------------
  assign chan_code_in_bit3 = sel_code[3];
  assign chan_code_in_bit2 = sel_code[2];
  assign chan_code_in_bit1 = sel_code[1];
  assign chan_code_in_bit0 = sel_code[0];
  // ----------------------------------------
  // Code seen by the scanner; a released line floats, so show a moving value
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (code_out_en_n) begin
      seen_code <= ~seen_code;
    end else begin
      seen_code <= {code_out_bit3, code_out_bit2, code_out_bit1, code_out_bit0};
    end
  end
endmodule
`default_nettype wire

// File: testbench/scanner_channel_sequencer_tb.sv
// Purpose: Self-checking bench for the scanner channel sequencer.
// Assumes: One second shortened to a few cycles by parameter.
// Notes:   Stimulus is driven by register tasks, the scanner model and a direct reading strobe.
`default_nettype none
module scanner_channel_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 10;       // Short second keeps dwell waits small
  logic        sys_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [3:0]  sel_code;
  logic [3:0]  active_chan;
  logic [7:0]  active_curve;
  logic        scan_active;
  logic        out_en_n;
  logic [23:0] reading;
  logic        reading_valid;
  logic [3:0]  seen_code;
  logic [3:0]  prev;
  wire  [3:0]  ci;               // Scanner to device code
  wire  [3:0]  co;               // Device to scanner code
  int          n_fail;
  int          checked;
  int          last;
  int          n;
  scs_sequencer #(.SECOND_CYCLES(SEC)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_code_in_bit3(ci[3]), .chan_code_in_bit2(ci[2]), .chan_code_in_bit1(ci[1]),
    .chan_code_in_bit0(ci[0]), .chan_code_out_bit3(co[3]), .chan_code_out_bit2(co[2]),
    .chan_code_out_bit1(co[1]), .chan_code_out_bit0(co[0]), .chan_code_out_en(out_en_n),
    .active_chan(active_chan), .active_curve(active_curve), .scan_active(scan_active),
    .reading(reading), .reading_valid(reading_valid));
  scs_scanner_model u_scanner (
    .sys_clk(sys_clk), .sel_code(sel_code), .code_out_bit3(co[3]), .code_out_bit2(co[2]),
    .code_out_bit1(co[1]), .code_out_bit0(co[0]), .code_out_en_n(out_en_n),
    .chan_code_in_bit3(ci[3]), .chan_code_in_bit2(ci[2]), .chan_code_in_bit1(ci[1]),
    .chan_code_in_bit0(ci[0]), .seen_code(seen_code));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_chan(input logic [3:0] v);
    int k;
    k = 0;
    while (active_chan !== v && k < 20) begin
      tick(1);
      k++;
    end
    if (active_chan !== v) begin
      n_fail++;
      finish_test();
    end
  endtask
  function automatic logic [3:0] next_en(input logic [3:0] cur, input logic [15:0] m);
    logic [3:0] c;
    for (int k = 1; k <= 16; k++) begin
      c = cur + 4'(k);
      if (m[c]) return c;
    end
    return cur;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    sel_code = 4'h0; reading = 24'h0; reading_valid = 1'b0; n_fail = 0; checked = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rc(scs_pkg::ADDR_DWELL, 32'h2, "dwell_rst");
    rc(scs_pkg::ADDR_ENABLE, 32'hffff, "enable_rst");
    rc(scs_pkg::ADDR_SETUP, 32'h0, "setup_rst");
    rc(scs_pkg::ADDR_MANUAL, 32'h0, "manual_rst");
    rc(8'hfc, 32'h0, "unmapped");
    wr(scs_pkg::ADDR_GLOBAL, 32'h5a5a0f0f);
    rc(scs_pkg::ADDR_GLOBAL, 32'h5a5a0f0f, "global");
    chk("off_en", {31'h0, out_en_n}, 32'h1);
    wr(scs_pkg::ADDR_DWELL, 32'h1);
    rc(scs_pkg::ADDR_DWELL, 32'h2, "dwell_lo");
    wr(scs_pkg::ADDR_DWELL, 32'hc9);
    rc(scs_pkg::ADDR_DWELL, 32'hc8, "dwell_hi");
    wr(scs_pkg::ADDR_DWELL, 32'h2);
    // Manual mode with outputs in scanner function, every channel
    wr(scs_pkg::ADDR_MODE, 32'h5);
    for (int c = 0; c < 16; c++) begin
      wr(scs_pkg::ADDR_SETUP, 32'(c));
      wr(scs_pkg::ADDR_CURVE, 32'h30 + 32'(c));
      rc(scs_pkg::ADDR_CURVE, 32'h30 + 32'(c), "curve_rb");
      wr(scs_pkg::ADDR_MANUAL, 32'(c));
      tick(2);
      chk("manual_chan", {28'h0, active_chan}, 32'(c));
      chk("manual_pins", {27'h0, co, out_en_n}, {27'h0, 4'(c), 1'b0});
      chk("active_curve", {24'h0, active_curve}, 32'h30 + 32'(c));
    end
    // Scanner function off: outputs released even in manual mode
    wr(scs_pkg::ADDR_MODE, 32'h1);
    tick(2);
    chk("nofunc_pins", {27'h0, co, out_en_n}, 32'h1);
    // Last valid reading of a channel is held after it goes inactive
    wr(scs_pkg::ADDR_MANUAL, 32'h3);
    repeat (2) @(posedge sys_clk);
    reading       <= 24'h00abcd;
    reading_valid <= 1'b1;
    @(posedge sys_clk);
    reading_valid <= 1'b0;
    rc(scs_pkg::ADDR_SAMPLE, 32'h00abcd, "sample");
    wr(scs_pkg::ADDR_MANUAL, 32'h5);
    wr(scs_pkg::ADDR_SETUP, 32'h3);
    rc(scs_pkg::ADDR_HELD, 32'h00abcd, "held");
    rc(scs_pkg::ADDR_STATUS, 32'h15, "status");
    // Slave mode follows the scanner; function bit must not drive outputs
    wr(scs_pkg::ADDR_MODE, 32'h7);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      sel_code <= (i == 0) ? 4'h9 : (i == 1) ? 4'hb : 4'h2;
      tick(1);
      wait_chan(sel_code);
      chk("slave_chan", {28'h0, active_chan}, {28'h0, sel_code});
      chk("slave_en", {31'h0, out_en_n}, 32'h1);
    end
    // Off mode ignores the scanner and releases outputs
    wr(scs_pkg::ADDR_MODE, 32'h4);
    sel_code <= 4'h4;
    tick(12);
    chk("off_chan", {28'h0, active_chan}, 32'h2);
    chk("off_flags", {30'h0, scan_active, out_en_n}, 32'h1);
    // Timed sequence over a sparse mask, through the wrap
    wr(scs_pkg::ADDR_ENABLE, 32'h8421);
    wr(scs_pkg::ADDR_MODE, 32'h6);
    prev = active_chan;
    last = 0;
    n    = 0;
    for (int t = 0; t < 400 && n < 5; t++) begin
      tick(1);
      if (active_chan !== prev) begin
        if (n > 0) chk("dwell", 32'(t - last), 32'(2 * SEC));
        chk("next", {28'h0, active_chan}, {28'h0, next_en(prev, 16'h8421)});
        chk("auto_pins", {27'h0, co, out_en_n}, {27'h0, active_chan, 1'b0});
        prev = active_chan;
        last = t;
        n++;
      end
    end
    chk("auto_steps", 32'(n), 32'h5);
    // Scanner latches the pins one edge after they change
    tick(1);
    chk("scanner_view", {28'h0, seen_code}, {28'h0, active_chan});
    // One enabled channel stays selected
    wr(scs_pkg::ADDR_ENABLE, 32'h0080);
    tick(60);
    chk("single", {28'h0, active_chan}, 32'h7);
    tick(60);
    chk("single_hold", {28'h0, active_chan}, 32'h7);
    finish_test();
  end
  // Watchdog ends a hung run through the same report
  initial begin
    #2500000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
